// ===== pkg/pll_lf_cfg_pkg.sv
package pll_lf_cfg_pkg;

   // register offsets on the host register port
   localparam logic [7:0] OFS_CP_CTRL = 8'h23;
   localparam logic [7:0] OFS_LF_R2 = 8'h24;
   localparam logic [7:0] OFS_LF_C1 = 8'h25;
   localparam logic [7:0] OFS_LF_R3 = 8'h26;
   localparam logic [7:0] OFS_LF_C3 = 8'h27;

   // field positions and widths
   localparam int CP_PHASE_LSB = 4;
   localparam int CP_PHASE_W = 3;
   localparam int C3_EN_BIT = 2;
   localparam int CP_RSVD_LSB = 0;
   localparam int CP_RSVD_W = 2;
   localparam int R2_W = 8;
   localparam int C1_W = 3;
   localparam int R3_W = 7;
   localparam int C3_W = 3;

   // reset values
   localparam logic [2:0] RST_CP_PHASE = 3'h0;
   localparam logic [0:0] RST_C3_EN = 1'h0;
   localparam logic [1:0] RST_CP_RSVD = 2'h3;
   localparam logic [7:0] RST_LF_R2 = 8'h08;
   localparam logic [2:0] RST_LF_C1 = 3'h0;
   localparam logic [6:0] RST_LF_R3 = 7'h00;
   localparam logic [2:0] RST_LF_C3 = 3'h0;

   // phase delay in picoseconds per code
   localparam logic [10:0] DLY_0_PS = 11'h000;
   localparam logic [10:0] DLY_1P3_PS = 11'h514;
   localparam logic [10:0] DLY_1P0_PS = 11'h3e8;
   localparam logic [10:0] DLY_0P9_PS = 11'h384;
   localparam logic [10:0] DLY_0P7_PS = 11'h2bc;

   // capacitor scaling in pF
   localparam logic [8:0] C1_BASE_PF = 9'h005;
   localparam logic [8:0] C1_STEP_PF = 9'h032;
   localparam logic [5:0] C3_STEP_PF = 6'h05;

   // resistor values in ohm for the characterised codes
   localparam logic [11:0] R2_OHM_01 = 12'h0c8;
   localparam logic [11:0] R2_OHM_04 = 12'h1f4;
   localparam logic [11:0] R2_OHM_08 = 12'h2bc;
   localparam logic [11:0] R2_OHM_20 = 12'h640;
   localparam logic [11:0] R2_OHM_30 = 12'h960;
   localparam logic [11:0] R2_OHM_40 = 12'hc80;
   localparam logic [11:0] R3_OHM_00 = 12'h012;
   localparam logic [11:0] R3_OHM_03 = 12'h0cd;
   localparam logic [11:0] R3_OHM_08 = 12'h356;
   localparam logic [11:0] R3_OHM_09 = 12'h470;
   localparam logic [11:0] R3_OHM_0C = 12'h5ff;
   localparam logic [11:0] R3_OHM_11 = 12'h790;
   localparam logic [11:0] R3_OHM_14 = 12'h91f;

   // one register access from the serial host port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // static control lines into the analog loop
   typedef struct packed {
      logic [2:0] cp_phase_delay_sel;
      logic third_cap_enable;
      logic [7:0] loop_filter_r2_code;
      logic [2:0] loop_filter_c1_code;
      logic [6:0] loop_filter_r3_code;
      logic [2:0] loop_filter_c3_code;
   } lf_ctrl_t;

   // decoded values for monitoring
   typedef struct packed {
      logic [10:0] phase_delay_ps;
      logic pd_rate_50m;
      logic [8:0] c1_pf;
      logic [5:0] c3_pf;
      logic [11:0] r2_ohm;
      logic r2_ohm_known;
      logic [11:0] r3_ohm;
      logic r3_ohm_known;
   } lf_values_t;

endpackage

// ===== design/cfg_field.sv
`timescale 1ns/1ps
`default_nettype none

// one read-write field with its own reset value
module cfg_field #(
   parameter int W = 8,
   parameter logic [W-1:0] RESET = '0
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] q_o
);

   // field width must fit one byte register
   if (W < 1 || W > 8) begin : g_bad_width
      $error("cfg_field width out of range");
   end

   // store on write, default on reset
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         q_o <= RESET;
      end else if (wr_en_i) begin
         q_o <= wdata_i;
      end
   end

endmodule // cfg_field

`default_nettype wire

// ===== design/pll_loop_filter_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

module pll_loop_filter_config_regs (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire pll_lf_cfg_pkg::reg_req_t req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output pll_lf_cfg_pkg::lf_ctrl_t lf_ctrl_o,
   output pll_lf_cfg_pkg::lf_values_t lf_values_o
);

   ////////////////////////////////////////////////////////////////////////
   // address decode

   logic sel_cp;
   logic sel_r2;
   logic sel_c1;
   logic sel_r3;
   logic sel_c3;

   // write strobes per register
   assign sel_cp = req_i.wr && (req_i.addr == pll_lf_cfg_pkg::OFS_CP_CTRL);
   assign sel_r2 = req_i.wr && (req_i.addr == pll_lf_cfg_pkg::OFS_LF_R2);
   assign sel_c1 = req_i.wr && (req_i.addr == pll_lf_cfg_pkg::OFS_LF_C1);
   assign sel_r3 = req_i.wr && (req_i.addr == pll_lf_cfg_pkg::OFS_LF_R3);
   assign sel_c3 = req_i.wr && (req_i.addr == pll_lf_cfg_pkg::OFS_LF_C3);

   ////////////////////////////////////////////////////////////////////////
   // storage

   logic [2:0] phase_q;
   logic [0:0] c3en_q;
   logic [7:0] r2_q;
   logic [2:0] c1_q;
   logic [6:0] r3_q;
   logic [2:0] c3_q;

   cfg_field #(.W(pll_lf_cfg_pkg::CP_PHASE_W), .RESET(pll_lf_cfg_pkg::RST_CP_PHASE)) u_phase (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_en_i(sel_cp),
      .wdata_i(req_i.wdata[pll_lf_cfg_pkg::CP_PHASE_LSB +: pll_lf_cfg_pkg::CP_PHASE_W]),
      .q_o(phase_q)
   );

   cfg_field #(.W(1), .RESET(pll_lf_cfg_pkg::RST_C3_EN)) u_c3en (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_en_i(sel_cp),
      .wdata_i(req_i.wdata[pll_lf_cfg_pkg::C3_EN_BIT +: 1]),
      .q_o(c3en_q)
   );

   cfg_field #(.W(pll_lf_cfg_pkg::R2_W), .RESET(pll_lf_cfg_pkg::RST_LF_R2)) u_r2 (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_en_i(sel_r2),
      .wdata_i(req_i.wdata[pll_lf_cfg_pkg::R2_W-1:0]),
      .q_o(r2_q)
   );

   cfg_field #(.W(pll_lf_cfg_pkg::C1_W), .RESET(pll_lf_cfg_pkg::RST_LF_C1)) u_c1 (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_en_i(sel_c1),
      .wdata_i(req_i.wdata[pll_lf_cfg_pkg::C1_W-1:0]),
      .q_o(c1_q)
   );

   cfg_field #(.W(pll_lf_cfg_pkg::R3_W), .RESET(pll_lf_cfg_pkg::RST_LF_R3)) u_r3 (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_en_i(sel_r3),
      .wdata_i(req_i.wdata[pll_lf_cfg_pkg::R3_W-1:0]),
      .q_o(r3_q)
   );

   cfg_field #(.W(pll_lf_cfg_pkg::C3_W), .RESET(pll_lf_cfg_pkg::RST_LF_C3)) u_c3 (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_en_i(sel_c3),
      .wdata_i(req_i.wdata[pll_lf_cfg_pkg::C3_W-1:0]),
      .q_o(c3_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // read-back

   logic [7:0] next_rdata;

   // assemble read value, unused bits zero, control reserved bits 1:0 read 2'h3, unmapped reads zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (req_i.addr)
         pll_lf_cfg_pkg::OFS_CP_CTRL: begin
            next_rdata[pll_lf_cfg_pkg::CP_PHASE_LSB +: pll_lf_cfg_pkg::CP_PHASE_W] = phase_q;
            next_rdata[pll_lf_cfg_pkg::C3_EN_BIT] = c3en_q[0];
            next_rdata[pll_lf_cfg_pkg::CP_RSVD_LSB +: pll_lf_cfg_pkg::CP_RSVD_W] =
               pll_lf_cfg_pkg::RST_CP_RSVD;
         end
         pll_lf_cfg_pkg::OFS_LF_R2: next_rdata = r2_q;
         pll_lf_cfg_pkg::OFS_LF_C1: next_rdata[pll_lf_cfg_pkg::C1_W-1:0] = c1_q;
         pll_lf_cfg_pkg::OFS_LF_R3: next_rdata[pll_lf_cfg_pkg::R3_W-1:0] = r3_q;
         pll_lf_cfg_pkg::OFS_LF_C3: next_rdata[pll_lf_cfg_pkg::C3_W-1:0] = c3_q;
         default: next_rdata = 8'h00;
      endcase
   end

   // read answer one cycle after the request
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= req_i.rd;
         if (req_i.rd) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // analog control lines

   // registered copies so outputs come from flip-flops
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lf_ctrl_o.cp_phase_delay_sel <= pll_lf_cfg_pkg::RST_CP_PHASE;
         lf_ctrl_o.third_cap_enable <= pll_lf_cfg_pkg::RST_C3_EN[0];
         lf_ctrl_o.loop_filter_r2_code <= pll_lf_cfg_pkg::RST_LF_R2;
         lf_ctrl_o.loop_filter_c1_code <= pll_lf_cfg_pkg::RST_LF_C1;
         lf_ctrl_o.loop_filter_r3_code <= pll_lf_cfg_pkg::RST_LF_R3;
         lf_ctrl_o.loop_filter_c3_code <= pll_lf_cfg_pkg::RST_LF_C3;
      end else begin
         lf_ctrl_o.cp_phase_delay_sel <= phase_q;
         lf_ctrl_o.third_cap_enable <= c3en_q[0];
         lf_ctrl_o.loop_filter_r2_code <= r2_q;
         lf_ctrl_o.loop_filter_c1_code <= c1_q;
         lf_ctrl_o.loop_filter_r3_code <= r3_q;
         lf_ctrl_o.loop_filter_c3_code <= c3_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoded values

   pll_lf_cfg_pkg::lf_values_t next_values;

   // translate codes into physical quantities
   always_comb begin
      next_values = '0;
      unique case (phase_q)
         3'h1, 3'h4: next_values.phase_delay_ps = pll_lf_cfg_pkg::DLY_1P3_PS;
         3'h2, 3'h5: next_values.phase_delay_ps = pll_lf_cfg_pkg::DLY_1P0_PS;
         3'h3, 3'h6: next_values.phase_delay_ps = pll_lf_cfg_pkg::DLY_0P9_PS;
         3'h7: next_values.phase_delay_ps = pll_lf_cfg_pkg::DLY_0P7_PS;
         default: next_values.phase_delay_ps = pll_lf_cfg_pkg::DLY_0_PS;
      endcase
      next_values.pd_rate_50m = phase_q[2];
      next_values.c1_pf = 9'(pll_lf_cfg_pkg::C1_BASE_PF + pll_lf_cfg_pkg::C1_STEP_PF * c1_q);
      next_values.c3_pf = 6'(pll_lf_cfg_pkg::C3_STEP_PF * c3_q);
      next_values.r2_ohm_known = 1'b1;
      unique case (r2_q)
         8'h01: next_values.r2_ohm = pll_lf_cfg_pkg::R2_OHM_01;
         8'h04: next_values.r2_ohm = pll_lf_cfg_pkg::R2_OHM_04;
         8'h08: next_values.r2_ohm = pll_lf_cfg_pkg::R2_OHM_08;
         8'h20: next_values.r2_ohm = pll_lf_cfg_pkg::R2_OHM_20;
         8'h30: next_values.r2_ohm = pll_lf_cfg_pkg::R2_OHM_30;
         8'h40: next_values.r2_ohm = pll_lf_cfg_pkg::R2_OHM_40;
         default: next_values.r2_ohm_known = 1'b0;
      endcase
      next_values.r3_ohm_known = 1'b1;
      unique case (r3_q)
         7'h00: next_values.r3_ohm = pll_lf_cfg_pkg::R3_OHM_00;
         7'h03: next_values.r3_ohm = pll_lf_cfg_pkg::R3_OHM_03;
         7'h08: next_values.r3_ohm = pll_lf_cfg_pkg::R3_OHM_08;
         7'h09: next_values.r3_ohm = pll_lf_cfg_pkg::R3_OHM_09;
         7'h0c: next_values.r3_ohm = pll_lf_cfg_pkg::R3_OHM_0C;
         7'h11: next_values.r3_ohm = pll_lf_cfg_pkg::R3_OHM_11;
         7'h14: next_values.r3_ohm = pll_lf_cfg_pkg::R3_OHM_14;
         default: next_values.r3_ohm_known = 1'b0;
      endcase
   end

   // hold decoded values in flip-flops
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lf_values_o <= '0;
      end else begin
         lf_values_o <= next_values;
      end
   end

endmodule // pll_loop_filter_config_regs

`default_nettype wire

// ===== tb/pll_lf_cfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// protocol and field checks on the register bank ports
module pll_lf_cfg_asserts (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire pll_lf_cfg_pkg::reg_req_t req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire pll_lf_cfg_pkg::lf_ctrl_t lf_ctrl_o,
   input wire pll_lf_cfg_pkg::lf_values_t lf_values_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // write strobes per register
   wire logic w23 = req_i.wr && req_i.addr == 8'h23;
   wire logic w24 = req_i.wr && req_i.addr == 8'h24;
   wire logic w25 = req_i.wr && req_i.addr == 8'h25;
   wire logic w26 = req_i.wr && req_i.addr == 8'h26;
   wire logic w27 = req_i.wr && req_i.addr == 8'h27;
   property p_phase;
      w23 |-> ##2 lf_ctrl_o.cp_phase_delay_sel == $past(req_i.wdata[6:4], 2);
   endproperty
   a_phase: assert property (p_phase) else $error("phase select not loaded");
   property p_cap;
      w23 |-> ##2 lf_ctrl_o.third_cap_enable == $past(req_i.wdata[2], 2);
   endproperty
   a_cap: assert property (p_cap) else $error("cap enable not loaded");
   property p_r2;
      w24 |-> ##2 lf_ctrl_o.loop_filter_r2_code == $past(req_i.wdata, 2);
   endproperty
   a_r2: assert property (p_r2) else $error("r2 code not loaded");
   property p_r3;
      w26 |-> ##2 lf_ctrl_o.loop_filter_r3_code == $past(req_i.wdata[6:0], 2);
   endproperty
   a_r3: assert property (p_r3) else $error("r3 code not loaded");
   property p_rate;
      lf_values_o.pd_rate_50m == lf_ctrl_o.cp_phase_delay_sel[2];
   endproperty
   a_rate: assert property (p_rate) else $error("comparison rate wrong");
   property p_c1pf;
      // decode of the defaults shows one edge after reset release
      !$past(rst_i) |->
         lf_values_o.c1_pf == 9'h005 + 9'h032 * lf_ctrl_o.loop_filter_c1_code;
   endproperty
   a_c1pf: assert property (p_c1pf) else $error("c1 capacitance wrong");
   property p_c3pf;
      lf_values_o.c3_pf == 6'h05 * lf_ctrl_o.loop_filter_c3_code;
   endproperty
   a_c3pf: assert property (p_c3pf) else $error("c3 capacitance wrong");
   property p_rsv;
      req_i.rd && req_i.addr == 8'h23 |=> reg_rvalid_o && reg_rdata_o[1:0] == 2'h3
         && !reg_rdata_o[7] && !reg_rdata_o[3];
   endproperty
   a_rsv: assert property (p_rsv) else $error("control readback reserved bits wrong");
   property p_c1;
      w25 |-> ##2 lf_ctrl_o.loop_filter_c1_code == $past(req_i.wdata[2:0], 2);
   endproperty
   a_c1: assert property (p_c1) else $error("c1 code not loaded");
   property p_c3;
      w27 |-> ##2 lf_ctrl_o.loop_filter_c3_code == $past(req_i.wdata[2:0], 2);
   endproperty
   a_c3: assert property (p_c3) else $error("c3 code not loaded");
   property p_rvalid;
      reg_rvalid_o == $past(req_i.rd);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer not one cycle after request");
endmodule // pll_lf_cfg_asserts

`default_nettype wire

// ===== tb/tb_pll_loop_filter_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pll_loop_filter_config_regs;
   logic clk_sys_i = 1'h0;
   logic rst_i = 1'h1;
   pll_lf_cfg_pkg::reg_req_t req_i = '0;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   pll_lf_cfg_pkg::lf_ctrl_t lf_ctrl_o;
   pll_lf_cfg_pkg::lf_values_t lf_values_o;
   int n_mismatch = 0;
   int compares = 0;
   int seed = 32'h1f47_6dc7;
   logic [7:0] sh [5];
   logic [7:0] a;
   logic [7:0] r;
   // listed resistor codes, the last R2 entry is an unlisted code
   logic [7:0] r2c [7] = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h30, 8'h40, 8'h02};
   logic [7:0] r3c [7] = '{8'h00, 8'h03, 8'h08, 8'h09, 8'h0c, 8'h11, 8'h14};

   pll_loop_filter_config_regs i_pll_loop_filter_config_regs (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .req_i(req_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .lf_ctrl_o(lf_ctrl_o), .lf_values_o(lf_values_o));

   // 250 MHz clock
   initial forever #2 clk_sys_i = ~clk_sys_i;

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // expected readback of a written byte
   function automatic logic [7:0] rb(input logic [7:0] ad, input logic [7:0] d);
      case (ad)
         8'h23: rb = {1'h0, d[6:4], 1'h0, d[2], 2'h3};
         8'h24: rb = d;
         8'h26: rb = {1'h0, d[6:0]};
         8'h25, 8'h27: rb = {5'h00, d[2:0]};
         default: rb = 8'h00;
      endcase
   endfunction

   function automatic logic [10:0] dly(input logic [2:0] c);
      case (c)
         3'h0: dly = 11'h000;
         3'h1, 3'h4: dly = 11'h514;
         3'h2, 3'h5: dly = 11'h3e8;
         3'h3, 3'h6: dly = 11'h384;
         default: dly = 11'h2bc;
      endcase
   endfunction

   // expected R2 value as {known, ohm}
   function automatic logic [12:0] r2o(input logic [7:0] c);
      case (c)
         8'h01: r2o = {1'h1, 12'h0c8};
         8'h04: r2o = {1'h1, 12'h1f4};
         8'h08: r2o = {1'h1, 12'h2bc};
         8'h20: r2o = {1'h1, 12'h640};
         8'h30: r2o = {1'h1, 12'h960};
         8'h40: r2o = {1'h1, 12'hc80};
         default: r2o = 13'h0000;
      endcase
   endfunction

   // expected R3 value as {known, ohm}
   function automatic logic [12:0] r3o(input logic [6:0] c);
      case (c)
         7'h00: r3o = {1'h1, 12'h012};
         7'h03: r3o = {1'h1, 12'h0cd};
         7'h08: r3o = {1'h1, 12'h356};
         7'h09: r3o = {1'h1, 12'h470};
         7'h0c: r3o = {1'h1, 12'h5ff};
         7'h11: r3o = {1'h1, 12'h790};
         7'h14: r3o = {1'h1, 12'h91f};
         default: r3o = 13'h0000;
      endcase
   endfunction

   task automatic do_reset(input int n);
      @(posedge clk_sys_i) rst_i <= 1'h1;
      repeat (n - 1) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      sh = '{8'h03, 8'h08, 8'h00, 8'h00, 8'h00};
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_sys_i) req_i <= {1'h1, 1'h0, ad, d};
      @(posedge clk_sys_i) req_i <= '0;
      if (ad inside {[8'h23:8'h27]}) sh[ad - 8'h23] = rb(ad, d);
   endtask

   // read one register, then compare readback and the control outputs
   task automatic rd(input logic [7:0] ad);
      int i;
      i = 1;
      @(posedge clk_sys_i) req_i <= {1'h0, 1'h1, ad, 8'h00};
      // taken at this edge, the answer stands in the cycle after it
      @(posedge clk_sys_i) req_i <= '0;
      #1;
      while (reg_rvalid_o !== 1'h1 && i < 4) begin
         @(posedge clk_sys_i);
         #1;
         i++;
      end
      cmp("read latency", 1, i);
      if (i == 4) begin
         wrap_up();
      end else begin
         cmp("rdata", ad inside {[8'h23:8'h27]} ? sh[ad - 8'h23] : 8'h00, reg_rdata_o);
         cmp("ctrl", {sh[0][6:4], sh[0][2], sh[1], sh[2][2:0], sh[3][6:0], sh[4][2:0]},
            lf_ctrl_o);
         cmp("delay", dly(sh[0][6:4]), lf_values_o.phase_delay_ps);
         cmp("rate", sh[0][6], lf_values_o.pd_rate_50m);
         cmp("c1 pf", 9'h005 + 9'h032 * sh[2][2:0], lf_values_o.c1_pf);
         cmp("c3 pf", 6'h05 * sh[4][2:0], lf_values_o.c3_pf);
         cmp("r2 ohm", r2o(sh[1]), {lf_values_o.r2_ohm_known, lf_values_o.r2_ohm});
         cmp("r3 ohm", r3o(sh[3][6:0]), {lf_values_o.r3_ohm_known, lf_values_o.r3_ohm});
      end
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      n_mismatch++;
      wrap_up();
   end

   // main sequence
   initial begin
      do_reset(10);
      for (a = 8'h22; a <= 8'h28; a++) rd(a);
      $display("reset values done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h23, {1'h0, 3'(c), 1'h0, c[0], 2'h3});
         rd(8'h23);
      end
      $display("phase codes done");
      foreach (r2c[k]) begin
         wr(8'h24, r2c[k]);
         wr(8'h26, r3c[k]);
         rd(8'h26);
      end
      $display("resistor codes done");
      repeat (60) begin
         a = 8'h22 + 8'({$random(seed)} % 7);
         r = 8'($random(seed));
         // mapped registers get their reserved bits at the legal values
         wr(a, a inside {[8'h23:8'h27]} ? rb(a, r) : r);
         r = 8'($random(seed));
         wr(8'h27, rb(8'h27, r));
         rd(a);
      end
      $display("random writes done");
      do_reset(2);
      rd(8'h24);
      rd(8'h23);
      $display("second reset done");
      wrap_up();
   end
endmodule // tb_pll_loop_filter_config_regs

bind pll_loop_filter_config_regs pll_lf_cfg_asserts i_pll_lf_cfg_asserts (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .lf_ctrl_o(lf_ctrl_o), .lf_values_o(lf_values_o));

`default_nettype wire
